// ### rtl/lmsd_top.sv
// Multiplexed scan logic of a common-cathode LED driver with hex font,
// pin 9 function select, two input ports and bus spike filters.
// Assumes an APB master on pclk and tri-state pads outside the block.
//
// Summary of operation
// - Four phases; digit pin sinks, segments source.
// - Idle shared pins float at high impedance.
// - Fixed phase map of cathode and segments.
// - Per digit: direct bits or hex font.
// - Eight extra segments: decimal points or indicators.
// - Dual digits: only extras 4-7 as points.
// - Pin 9: segment, open-drain interrupt, or logic.
// - Each input port: logic input or keyscan.
// - Bus inputs ignore spikes under 50 ns.
// - Nine segments per digit.
// - Interrupt flags key events; status always readable.
`timescale 1ns/1ps

module lmsd_top #(
    parameter int PHASE_CYCLES = lmsd_pkg::PHASE_CYCLES,
    parameter int BLANK_CYCLES = lmsd_pkg::BLANK_CYCLES
) (
    // APB clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Shared digit/segment pins 0 to 3.
    output logic [3:0] shared_pin_level,
    output logic [3:0] shared_pin_en,
    // Anode pins 4 to 8 (e, d, c, b, a).
    output logic [4:0] anode_pin_level,
    output logic [4:0] anode_pin_en,
    // Multi-function pin 9.
    output logic multi_function_level,
    output logic multi_function_en,
    output logic irq,
    // Input ports.
    input wire logic input_port_one,
    input wire logic input_port_two,
    // Two-wire bus lines, raw and filtered.
    input wire logic scl_raw,
    input wire logic sda_raw,
    output logic scl_clean,
    output logic sda_clean
);
    import lmsd_pkg::*;

    // ********************************************************************
    // Hex font: bit 0 is segment a up to bit 6 for segment g.
    // ********************************************************************
    function automatic logic [6:0] hex_font(input logic [3:0] v);
        logic [6:0] p;
        p = 7'h00;
        case (v)
            4'h0: p = 7'h3f;
            4'h1: p = 7'h06;
            4'h2: p = 7'h5b;
            4'h3: p = 7'h4f;
            4'h4: p = 7'h66;
            4'h5: p = 7'h6d;
            4'h6: p = 7'h7d;
            4'h7: p = 7'h07;
            4'h8: p = 7'h7f;
            4'h9: p = 7'h6f;
            4'ha: p = 7'h77;
            4'hb: p = 7'h7c;
            4'hc: p = 7'h39;
            4'hd: p = 7'h5e;
            4'he: p = 7'h79;
            default: p = 7'h71;
        endcase
        return p;
    endfunction

    // ********************************************************************
    // State.
    // ********************************************************************
    logic [CTL_WIDTH-1:0] ctl_r, ctl_nxt; // Control register.
    logic [6:0] digit_r [4]; // Digit data, direct bits or hex value.
    logic [6:0] digit_nxt [4];
    logic [7:0] extra_r, extra_nxt; // Extra single-LED segments.
    logic [EV_WIDTH-1:0] status_r, status_nxt; // Sticky events.
    logic [EV_WIDTH-1:0] mask_r, mask_nxt; // Interrupt enables.
    logic [31:0] cnt_r, cnt_nxt; // Cycle within the phase.
    logic [1:0] phase_r, phase_nxt; // Digit phase.
    logic [1:0] inp_prev_r; // Input levels one cycle back.
    logic [31:0] prdata_nxt;
    logic pready_nxt, pslverr_nxt;
    logic [3:0] sh_lvl_nxt, sh_en_nxt;
    logic [4:0] an_lvl_nxt, an_en_nxt;
    logic mf_lvl_nxt, mf_en_nxt, irq_nxt;
    logic active; // Phase lit, outside the dark gap.
    logic wr; // Write completes this cycle.
    logic [EV_WIDTH-1:0] events;
    logic [6:0] seg7; // Seven segments of the current digit.
    logic addr_ok;

    // ********************************************************************
    // Spike filters on the bus inputs.
    // ********************************************************************
    lmsd_glitch_filter #(.STABLE_CYCLES(SPIKE_CYCLES)) u_scl_filter (
        .pclk(pclk),
        .presetn(presetn),
        .raw(scl_raw),
        .clean_r(scl_clean)
    );

    lmsd_glitch_filter #(.STABLE_CYCLES(SPIKE_CYCLES)) u_sda_filter (
        .pclk(pclk),
        .presetn(presetn),
        .raw(sda_raw),
        .clean_r(sda_clean)
    );

    // ********************************************************************
    // Scan timing.
    // ********************************************************************

    // Free-running phase counter; phases advance in a fixed ring.
    always_comb
    begin
        cnt_nxt = cnt_r + 32'h1;
        phase_nxt = phase_r;
        if (cnt_r == 32'(PHASE_CYCLES - 1))
        begin
            cnt_nxt = 32'h0;
            phase_nxt = phase_r + 2'h1;
        end
    end

    // The first cycles of each phase stay dark so the old digit's charge
    // cannot ghost onto the new one.
    assign active = ctl_r[CTL_SCAN_EN] && (cnt_r >= 32'(BLANK_CYCLES));

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_r <= 32'h0;
            phase_r <= 2'h0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            phase_r <= phase_nxt;
        end
    end

    // ********************************************************************
    // Pin drive.
    // ********************************************************************

    // Segments of the digit in this phase, direct or through the font.
    always_comb
    begin
        if (ctl_r[CTL_DECODE_LO + phase_r])
        begin
            seg7 = hex_font(digit_r[phase_r][3:0]);
        end
        else
        begin
            seg7 = digit_r[phase_r];
        end
    end

    // Every pin not sinking or sourcing is left floating.
    always_comb
    begin
        sh_lvl_nxt = 4'h0;
        sh_en_nxt = 4'h0;
        an_lvl_nxt = 5'h1f;
        an_en_nxt = 5'h00;
        mf_lvl_nxt = 1'b0;
        mf_en_nxt = 1'b0;
        if (active)
        begin
            // Own pin sinks the cathode.
            sh_en_nxt[phase_r] = 1'b1;
            sh_lvl_nxt[phase_r] = 1'b0;
            // Neighbour pin carries extra segment of this phase; with dual
            // digits this pin is the partner cathode, so it feeds only LEDs.
            sh_en_nxt[phase_r ^ 2'h1] = extra_r[phase_r];
            sh_lvl_nxt[phase_r ^ 2'h1] = 1'b1;
            // The other pair carries g then f.
            if (phase_r < 2'h2)
            begin
                sh_en_nxt[2] = seg7[6];
                sh_en_nxt[3] = seg7[5];
                sh_lvl_nxt[3:2] = 2'h3;
            end
            else
            begin
                sh_en_nxt[0] = seg7[6];
                sh_en_nxt[1] = seg7[5];
                sh_lvl_nxt[1:0] = 2'h3;
            end
            // Pins 4 to 8 carry e, d, c, b, a.
            an_en_nxt = {seg7[0], seg7[1], seg7[2], seg7[3], seg7[4]};
        end
        case (ctl_r[CTL_PIN9_LO +: 2])
            PIN9_SEGMENT:
            begin
                // Ninth segment, or decimal point of this digit.
                mf_en_nxt = active && extra_r[3'h4 + {1'b0, phase_r}];
                mf_lvl_nxt = 1'b1;
            end
            PIN9_IRQ:
            begin
                mf_en_nxt = irq_nxt;
            end
            PIN9_GPO:
            begin
                mf_en_nxt = !ctl_r[CTL_GPO];
            end
            default:
            begin
                mf_en_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            shared_pin_level <= 4'h0;
            shared_pin_en <= 4'h0;
            anode_pin_level <= 5'h1f;
            anode_pin_en <= 5'h00;
            multi_function_level <= 1'b0;
            multi_function_en <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            shared_pin_level <= sh_lvl_nxt;
            shared_pin_en <= sh_en_nxt;
            anode_pin_level <= an_lvl_nxt;
            anode_pin_en <= an_en_nxt;
            multi_function_level <= mf_lvl_nxt;
            multi_function_en <= mf_en_nxt;
            irq <= irq_nxt;
        end
    end

    // ********************************************************************
    // Events and interrupt.
    // ********************************************************************

    // A port in keyscan mode reports each level change as a key event.
    // Debouncing is left to the key matrix logic outside this block.
    always_comb
    begin
        events = '0;
        events[EV_KEY1] = ctl_r[CTL_KEY1] && (input_port_one != inp_prev_r[0]);
        events[EV_KEY2] = ctl_r[CTL_KEY2] && (input_port_two != inp_prev_r[1]);
        events[EV_SCAN] = (phase_r == 2'h3) && (cnt_r == 32'(PHASE_CYCLES - 1));
    end

    // Status already set or freshly flagged drives the interrupt.
    assign irq_nxt = |(status_nxt & mask_r);

    // Inputs idle high through the pad pull-ups; reset matches that.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            inp_prev_r <= 2'h3;
        end
        else
        begin
            inp_prev_r <= {input_port_two, input_port_one};
        end
    end

    // ********************************************************************
    // APB register file.
    // ********************************************************************
    assign wr = psel && penable && pready && pwrite;

    always_comb
    begin
        case (paddr)
            ADDR_CONTROL, ADDR_DIGIT0, ADDR_DIGIT1, ADDR_DIGIT2, ADDR_DIGIT3,
            ADDR_EXTRA, ADDR_PORTS, ADDR_IRQ_STATUS, ADDR_IRQ_MASK: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    // Writes land on the completing access edge; a status event in the
    // same cycle as its clear keeps the bit set.
    always_comb
    begin
        ctl_nxt = ctl_r;
        digit_nxt = digit_r;
        extra_nxt = extra_r;
        mask_nxt = mask_r;
        status_nxt = status_r;
        if (wr)
        begin
            case (paddr)
                ADDR_CONTROL: ctl_nxt = pwdata[CTL_WIDTH-1:0];
                ADDR_DIGIT0: digit_nxt[0] = pwdata[6:0];
                ADDR_DIGIT1: digit_nxt[1] = pwdata[6:0];
                ADDR_DIGIT2: digit_nxt[2] = pwdata[6:0];
                ADDR_DIGIT3: digit_nxt[3] = pwdata[6:0];
                ADDR_EXTRA: extra_nxt = pwdata[7:0];
                ADDR_IRQ_STATUS: status_nxt = status_r & ~pwdata[EV_WIDTH-1:0];
                ADDR_IRQ_MASK: mask_nxt = pwdata[EV_WIDTH-1:0];
                default: ctl_nxt = ctl_r;
            endcase
        end
        status_nxt = status_nxt | events;
    end

    // Read data is captured in the setup cycle so it leaves a flip-flop;
    // ready follows one cycle later, giving a single access cycle.
    always_comb
    begin
        prdata_nxt = 32'h0;
        pready_nxt = psel && !penable;
        pslverr_nxt = psel && !penable && !addr_ok;
        if (psel && !penable && !pwrite)
        begin
            case (paddr)
                ADDR_CONTROL: prdata_nxt = {22'h0, ctl_r};
                ADDR_DIGIT0: prdata_nxt = {25'h0, digit_r[0]};
                ADDR_DIGIT1: prdata_nxt = {25'h0, digit_r[1]};
                ADDR_DIGIT2: prdata_nxt = {25'h0, digit_r[2]};
                ADDR_DIGIT3: prdata_nxt = {25'h0, digit_r[3]};
                ADDR_EXTRA: prdata_nxt = {24'h0, extra_r};
                ADDR_PORTS: prdata_nxt = {26'h0, sda_clean, scl_clean, phase_r,
                    input_port_two, input_port_one};
                ADDR_IRQ_STATUS: prdata_nxt = {29'h0, status_r};
                ADDR_IRQ_MASK: prdata_nxt = {29'h0, mask_r};
                default: prdata_nxt = 32'h0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctl_r <= CTL_RESET;
            for (int i = 0; i < 4; i++)
            begin
                digit_r[i] <= DIGIT_RESET;
            end
            extra_r <= EXTRA_RESET;
            mask_r <= MASK_RESET;
            status_r <= '0;
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            ctl_r <= ctl_nxt;
            digit_r <= digit_nxt;
            extra_r <= extra_nxt;
            mask_r <= mask_nxt;
            status_r <= status_nxt;
            prdata <= prdata_nxt;
            pready <= pready_nxt;
            pslverr <= pslverr_nxt;
        end
    end

    // ********************************************************************
    // Assertions.
    // ********************************************************************
    property p_cathode_sink;
        @(posedge pclk) disable iff (!presetn)
        $past(active) |-> shared_pin_en[$past(phase_r)] && !shared_pin_level[$past(phase_r)];
    endproperty
    a_cathode_sink: assert property (p_cathode_sink)
        else $error("Phase cathode pin is not sinking.");

    property p_dark_float;
        @(posedge pclk) disable iff (!presetn)
        !$past(active) |-> shared_pin_en == 4'h0 && anode_pin_en == 5'h00;
    endproperty
    a_dark_float: assert property (p_dark_float)
        else $error("A pin drives outside a lit phase.");

    property p_anode_map;
        @(posedge pclk) disable iff (!presetn)
        $past(active) |-> anode_pin_en[4] == $past(seg7[0]) && anode_pin_en[0] == $past(seg7[4]);
    endproperty
    a_anode_map: assert property (p_anode_map)
        else $error("Anode pins do not follow the segment map.");

    property p_direct_mode;
        @(posedge pclk) disable iff (!presetn)
        $past(active && !ctl_r[CTL_DECODE_LO + phase_r]) |->
            anode_pin_en == {$past(digit_r[phase_r][0]), $past(digit_r[phase_r][1]),
            $past(digit_r[phase_r][2]), $past(digit_r[phase_r][3]),
            $past(digit_r[phase_r][4])};
    endproperty
    a_direct_mode: assert property (p_direct_mode)
        else $error("Direct mode anodes differ from stored bits.");

    property p_irq_pin;
        @(posedge pclk) disable iff (!presetn)
        ctl_r[CTL_PIN9_LO +: 2] == PIN9_IRQ |=> multi_function_en == irq && !multi_function_level;
    endproperty
    a_irq_pin: assert property (p_irq_pin)
        else $error("Pin 9 does not follow the interrupt.");

    property p_key_event;
        @(posedge pclk) disable iff (!presetn)
        ctl_r[CTL_KEY1] && $changed(input_port_one) |=>
            status_r[EV_KEY1] && (irq || !$past(mask_r[EV_KEY1]));
    endproperty
    a_key_event: assert property (p_key_event)
        else $error("Key event on input one not flagged.");

    property p_irq_level;
        @(posedge pclk) disable iff (!presetn)
        irq == |(status_r & $past(mask_r));
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("Interrupt level does not match masked status.");

    property p_phase_dwell;
        @(posedge pclk) disable iff (!presetn)
        $changed(phase_r) |-> $past(cnt_r) == 32'(PHASE_CYCLES - 1) && cnt_r == 32'h0;
    endproperty
    a_phase_dwell: assert property (p_phase_dwell)
        else $error("Phase changed before its full dwell.");

endmodule

// ### rtl/lmsd_pkg.sv
// Package for the LED multiplex scan driver: register map, field layout,
// reset values and timing counts. Assumes a 200 MHz pclk.
package lmsd_pkg;

    // ********************************************************************
    // Clock and timing.
    // ********************************************************************
    localparam int CLK_MHZ = 200; // Bus clock rate in MHz.
    localparam int CLK_HZ = 200_000_000; // Bus clock rate in Hz.
    localparam int SPIKE_NS = 50; // Shortest bus pulse that passes the filter.
    // Least time a bus level must stand, rounded up to whole cycles.
    localparam int SPIKE_CYCLES = (SPIKE_NS * CLK_MHZ + 999) / 1000;
    localparam int SCAN_RATE_HZ = 780; // Full four-digit scan rate.
    localparam int PHASE_COUNT = 4; // Digit phases per scan.
    // Dwell of one digit phase, rounded down.
    localparam int PHASE_CYCLES = CLK_HZ / (SCAN_RATE_HZ * PHASE_COUNT);
    localparam int BLANK_NS = 1000; // Dark gap between phases.
    localparam int BLANK_CYCLES = (BLANK_NS * CLK_MHZ + 999) / 1000;

    // ********************************************************************
    // Register byte offsets.
    // ********************************************************************
    localparam logic [7:0] ADDR_CONTROL = 8'h00; // Mode and pin setup.
    localparam logic [7:0] ADDR_DIGIT0 = 8'h04; // Digit 0 data.
    localparam logic [7:0] ADDR_DIGIT1 = 8'h08; // Digit 1 data.
    localparam logic [7:0] ADDR_DIGIT2 = 8'h0c; // Digit 2 data.
    localparam logic [7:0] ADDR_DIGIT3 = 8'h10; // Digit 3 data.
    localparam logic [7:0] ADDR_EXTRA = 8'h14; // Eight extra segments.
    localparam logic [7:0] ADDR_PORTS = 8'h18; // Live pin and scan state.
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h1c; // Sticky events, W1C.
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h20; // Interrupt enables.

    // ********************************************************************
    // Control register fields.
    // ********************************************************************
    localparam int CTL_SCAN_EN = 0; // Scan running.
    localparam int CTL_DECODE_LO = 1; // Hex font per digit, bits 4:1.
    localparam int CTL_PIN9_LO = 5; // Pin 9 function, bits 6:5.
    localparam int CTL_KEY1 = 7; // Input one in keyscan mode.
    localparam int CTL_KEY2 = 8; // Input two in keyscan mode.
    localparam int CTL_GPO = 9; // Level of pin 9 as logic output.
    localparam int CTL_WIDTH = 10;
    localparam logic [CTL_WIDTH-1:0] CTL_RESET = 10'h000;

    // Pin 9 functions.
    localparam logic [1:0] PIN9_SEGMENT = 2'h0;
    localparam logic [1:0] PIN9_IRQ = 2'h1;
    localparam logic [1:0] PIN9_GPO = 2'h2;

    // Interrupt status bits.
    localparam int EV_KEY1 = 0; // Key event on input one.
    localparam int EV_KEY2 = 1; // Key event on input two.
    localparam int EV_SCAN = 2; // One full scan finished.
    localparam int EV_WIDTH = 3;

    localparam logic [6:0] DIGIT_RESET = 7'h00;
    localparam logic [7:0] EXTRA_RESET = 8'h00;
    localparam logic [EV_WIDTH-1:0] MASK_RESET = 3'h0;

endpackage

// ### rtl/lmsd_glitch_filter.sv
// Spike filter for one two-wire bus input.
// Assumes the raw input is already synchronous to pclk.
`timescale 1ns/1ps

module lmsd_glitch_filter #(
    parameter int STABLE_CYCLES = lmsd_pkg::SPIKE_CYCLES
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Raw and filtered level.
    input wire logic raw,
    output logic clean_r
);
    import lmsd_pkg::*;

    logic [7:0] cnt_r; // Cycles the raw level has differed.
    logic [7:0] cnt_nxt;
    logic clean_nxt;

    // A new level is taken only once it has stood the full time, so any
    // spike shorter than that never reaches the bus logic.
    always_comb
    begin
        cnt_nxt = 8'h00;
        clean_nxt = clean_r;
        if (raw != clean_r)
        begin
            if (cnt_r == 8'(STABLE_CYCLES - 1))
            begin
                clean_nxt = raw;
            end
            else
            begin
                cnt_nxt = cnt_r + 8'h01;
            end
        end
    end

    // Idle bus lines sit high.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_r <= 8'h00;
            clean_r <= 1'b1;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            clean_r <= clean_nxt;
        end
    end

    property p_spike_filter;
        @(posedge pclk) disable iff (!presetn)
        $changed(clean_r) |-> $past(cnt_r) == 8'(STABLE_CYCLES - 1);
    endproperty
    a_spike_filter: assert property (p_spike_filter)
        else $error("Filtered level changed before the raw level stood long enough.");

endmodule

// ### tb/lmsd_led_model.sv
// Display model: records the segments each common-cathode digit sees lit.
// Assumes the driver's registered pin outputs, sampled on pclk.
`timescale 1ns/1ps

module lmsd_led_model (
    // Clock.
    input wire logic pclk,
    // Driver pins.
    input wire logic [3:0] sp_level,
    input wire logic [3:0] sp_en,
    input wire logic [4:0] an_en,
    input wire logic mf_level,
    input wire logic mf_en,
    // Lit segments per digit as {pin9, extra, g, f, e, d, c, b, a}.
    output logic [8:0] seen [4],
    // Set once two cathodes ever sink together.
    output logic clash
);
    logic [3:0] sink; // Shared pins pulling a cathode low.
    int g; // Shared pin carrying segment g in this phase.
    assign sink = sp_en & ~sp_level;
    initial clash = 1'b0;
    // Latch segments under the sinking cathode; blank gaps latch nothing.
    always @(posedge pclk)
    begin
        if ($countones(sink) > 1)
            clash <= 1'b1;
        for (int k = 0; k < 4; k++)
        begin
            g = (k < 2) ? 2 : 0;
            if (sink[k])
                seen[k] <= {mf_en & mf_level, sp_en[k^1] & sp_level[k^1],
                    sp_en[g] & sp_level[g], sp_en[g+1] & sp_level[g+1],
                    an_en[0], an_en[1], an_en[2], an_en[3], an_en[4]};
        end
    end
endmodule

// ### tb/lmsd_top_test.sv
// Self-checking bench for the LED scan driver over APB, with display model.
// Assumes shortened scan counts: 40-clock phases with 4 dark clocks.
`timescale 1ns/1ps

module lmsd_top_test;
    import lmsd_pkg::*;
    // ************************************************************
    // Signals.
    // ************************************************************
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic in1 = 1'b1;
    logic in2 = 1'b1;
    logic scl_raw = 1'b1;
    logic sda_raw = 1'b1;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, mf_level, mf_en, irq, scl_clean, sda_clean, clash;
    logic [3:0] sp_level, sp_en;
    logic [4:0] an_en, an_level;
    logic [8:0] seen [4];
    int fail_count = 0;
    int n_tests = 0;
    int cycles = 0;

    always #2.5 pclk = ~pclk;

    lmsd_top #(.PHASE_CYCLES(40), .BLANK_CYCLES(4)) lmsd_top_inst (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .shared_pin_level(sp_level), .shared_pin_en(sp_en),
        .anode_pin_level(an_level), .anode_pin_en(an_en), .multi_function_level(mf_level),
        .multi_function_en(mf_en), .irq(irq), .input_port_one(in1),
        .input_port_two(in2), .scl_raw(scl_raw), .sda_raw(sda_raw),
        .scl_clean(scl_clean), .sda_clean(sda_clean));

    lmsd_led_model lmsd_led_model_inst (.pclk(pclk), .sp_level(sp_level),
        .sp_en(sp_en), .an_en(an_en), .mf_level(mf_level), .mf_en(mf_en),
        .seen(seen), .clash(clash));

    // ************************************************************
    // Tasks.
    // ************************************************************
    // Compare one value; an unknown never matches.
    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task close_out;
        $display("Checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // One APB transfer; pready and read data are taken at the rising edge.
    // Only the global timeout ends a wait that never sees pready.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
        begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Wait whole cycles, ending mid-cycle where outputs are settled.
    task settle(input int n);
        repeat (n) @(negedge pclk);
    endtask

    // A hang ends the run as a failure.
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            fail_count++;
            close_out;
        end
    end

    // ************************************************************
    // Tests.
    // ************************************************************
    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        settle(1);
        chk(sp_en, 0, "shared enables");
        chk(an_en, 0, "anode enables");
        chk(an_level, 5'h1f, "anode levels");
        apb(0, ADDR_CONTROL, 0);
        chk(rd, CTL_RESET, "control reset");
        apb(0, 8'h3c, 0);
        chk(err, 1, "unmapped error");
        $display("Test reset done");
        apb(1, ADDR_DIGIT0, 32'h5b);
        apb(1, ADDR_DIGIT1, 32'h1);
        apb(1, ADDR_DIGIT2, 32'h60);
        apb(1, ADDR_DIGIT3, 32'hf);
        apb(1, ADDR_EXTRA, 32'ha5);
        apb(1, ADDR_CONTROL, 32'h15);
        settle(240);
        chk(seen[0], 9'h0db, "digit 0 direct");
        chk(seen[1], 9'h106, "digit 1 font");
        chk(seen[2], 9'h0e0, "digit 2 map");
        chk(seen[3], 9'h171, "digit 3 font");
        chk(clash, 0, "cathode overlap");
        $display("Test scan done");
        apb(1, ADDR_CONTROL, 32'h040);
        settle(3);
        chk({sp_en, an_en}, 0, "pins floating");
        chk({mf_en, mf_level}, 2'b10, "pin9 logic low");
        apb(1, ADDR_CONTROL, 32'h240);
        settle(3);
        chk(mf_en, 0, "pin9 logic high");
        $display("Test pin9 done");
        apb(1, ADDR_IRQ_MASK, 1);
        apb(1, ADDR_CONTROL, 32'h0a0);
        @(posedge pclk);
        in1 <= 1'b0;
        settle(4);
        chk({irq, mf_en}, 2'b11, "irq on pin9");
        apb(0, ADDR_IRQ_STATUS, 0);
        // The free-running scan has long since flagged scan done, never cleared.
        chk(rd, 32'h5, "key status");
        apb(1, ADDR_IRQ_STATUS, 1);
        settle(2);
        chk(irq, 0, "irq cleared");
        apb(0, ADDR_PORTS, 0);
        chk(rd[1:0], 2'b10, "port levels");
        apb(1, ADDR_IRQ_MASK, 0);
        @(posedge pclk);
        in1 <= 1'b1;
        settle(4);
        chk(irq, 0, "masked irq");
        apb(0, ADDR_IRQ_STATUS, 0);
        chk(rd, 32'h5, "masked status");
        $display("Test keys done");
        @(posedge pclk);
        scl_raw <= 1'b0;
        repeat (5) @(posedge pclk);
        scl_raw <= 1'b1;
        sda_raw <= 1'b0;
        settle(15);
        chk(scl_clean, 1, "spike ignored");
        chk(sda_clean, 0, "level passed");
        $display("Test filter done");
        close_out;
    end
endmodule
